// file: hw/cam_defines.svh
// Sizes, reset values and timing counts of the content-addressable memory block.
`ifndef CAM_DEFINES_SVH
`define CAM_DEFINES_SVH
`define CAM_WORDS        32
`define CAM_WIDTH        32
`define CAM_ADDR_W       5
`define CAM_HALF         16
`define CAM_CARE_ALL     32'hffffffff
`define CAM_INIT_DATA    1024'h0
`define CAM_INIT_CARE    {32{32'hffffffff}}
`define CAM_WR_CYC_PLAIN 2
`define CAM_WR_CYC_MASK  3
`endif

// file: hw/cam_pkg.sv
// Types shared by the content-addressable memory block.
`include "cam_defines.svh"
package cam_pkg;
	typedef struct packed {
		logic [`CAM_ADDR_W-1:0] addr;
		logic [`CAM_WIDTH-1:0]  data;
		logic [`CAM_WIDTH-1:0]  care;
	} write_req_t;

	typedef enum logic [1:0] {WR_IDLE, WR_LOAD, WR_MASK} write_state_t;
	typedef enum logic {SR_IDLE, SR_UPPER} search_state_t;
endpackage

// file: hw/cam_match_encoder.sv
// Priority encoder turning a match vector into the lowest matching address.
`timescale 1ns/10ps
module cam_match_encoder #(
	parameter int N  = 32,
	parameter int AW = 5
) (
	input  wire logic [N-1:0]  hits,
	output logic      [AW-1:0] index,
	output logic               any
);
	// Scanning downward leaves the lowest hit; with duplicates the answer is only a hint.
	always_comb begin
		index = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (hits[i]) begin
				index = AW'(i);
			end
		end
		any = |hits;
	end
endmodule

// file: hw/content_addressable_memory_block.sv
// Content-addressable memory: 32 maskable words, encoded or two-cycle unencoded result.
//
// What this block does
// - It stores 32 words of 32 bits and compares a search word against all of them at once.
// - Bits written as don't-care are ignored when a word is tested for a match.
// - The result form, encoded or unencoded, is fixed by a static configuration.
// - In encoded form the result is the binary address of the matching word.
// - In unencoded form 16 match lines show all 32 words over two cycles, both to be sampled.
// - With several matches the encoded result may be wrong but the unencoded lines show each.
// - Words get initial contents at configuration and can be written during operation.
// - A write without don't-care bits takes two cycles; the request is latched, so the writer drives it for one cycle only.
// - A write with don't-care bits takes one cycle more, three in total.
`timescale 1ns/10ps
`include "cam_defines.svh"
module content_addressable_memory_block
	import cam_pkg::*;
#(
	parameter bit                              ENCODED_OUT = 1'b1,
	parameter logic [`CAM_WORDS*`CAM_WIDTH-1:0] INIT_DATA   = `CAM_INIT_DATA,
	parameter logic [`CAM_WORDS*`CAM_WIDTH-1:0] INIT_CARE   = `CAM_INIT_CARE
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   searchValid,
	input  wire logic [`CAM_WIDTH-1:0]  searchData,
	input  wire logic                   writeValid,
	input  wire write_req_t             writeReq,
	output logic                        searchReady,
	output logic                        writeBusy,
	output logic                        matchValid,
	output logic                        matchUpper,
	output logic                        matchFound,
	output logic [`CAM_ADDR_W-1:0]      matchAddr,
	output logic [`CAM_HALF-1:0]        matchLines
);
	// ------------------------------------------------------------
	// Storage and compare
	// ------------------------------------------------------------
	logic [`CAM_WIDTH-1:0] storeData_reg [`CAM_WORDS];
	logic [`CAM_WIDTH-1:0] storeData_next [`CAM_WORDS];
	logic [`CAM_WIDTH-1:0] storeCare_reg [`CAM_WORDS];
	logic [`CAM_WIDTH-1:0] storeCare_next [`CAM_WORDS];
	logic [`CAM_WORDS-1:0] hits;
	logic [`CAM_ADDR_W-1:0] hitIndex;
	logic                   hitAny;

	genvar g;
	generate
		for (g = 0; g < `CAM_WORDS; g++) begin : gen_cmp
			assign hits[g] = ((storeData_reg[g] ^ searchData) & storeCare_reg[g]) == '0;
		end
	endgenerate

	cam_match_encoder #(.N(`CAM_WORDS), .AW(`CAM_ADDR_W)) u_enc (
		.hits  (hits),
		.index (hitIndex),
		.any   (hitAny)
	);

	// ------------------------------------------------------------
	// Write sequencing
	// ------------------------------------------------------------
	write_state_t wrState_reg, wrState_next;
	write_req_t   wrHold_reg, wrHold_next;
	logic         busy_reg, busy_next;
	logic         wrTake;

	assign wrTake = writeValid && wrState_reg == WR_IDLE;

	always_comb begin
		wrState_next   = wrState_reg;
		wrHold_next    = wrHold_reg;
		storeData_next = storeData_reg;
		storeCare_next = storeCare_reg;
		case (wrState_reg)
			WR_IDLE: begin
				if (wrTake) begin
					wrHold_next  = writeReq;
					wrState_next = WR_LOAD;
				end
			end
			WR_LOAD: begin
				// The masked write needs a further cycle to place its care bits.
				if (wrHold_reg.care != `CAM_CARE_ALL) begin
					wrState_next = WR_MASK;
				end else begin
					storeData_next[wrHold_reg.addr] = wrHold_reg.data;
					storeCare_next[wrHold_reg.addr] = wrHold_reg.care;
					wrState_next = WR_IDLE;
				end
			end
			WR_MASK: begin
				storeData_next[wrHold_reg.addr] = wrHold_reg.data;
				storeCare_next[wrHold_reg.addr] = wrHold_reg.care;
				wrState_next = WR_IDLE;
			end
			default: wrState_next = WR_IDLE;
		endcase
		busy_next = wrState_next != WR_IDLE;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wrState_reg <= WR_IDLE;
			wrHold_reg  <= '0;
			busy_reg    <= 1'b0;
			for (int i = 0; i < `CAM_WORDS; i++) begin
				storeData_reg[i] <= INIT_DATA[i*`CAM_WIDTH +: `CAM_WIDTH];
				storeCare_reg[i] <= INIT_CARE[i*`CAM_WIDTH +: `CAM_WIDTH];
			end
		end else begin
			wrState_reg   <= wrState_next;
			wrHold_reg    <= wrHold_next;
			busy_reg      <= busy_next;
			storeData_reg <= storeData_next;
			storeCare_reg <= storeCare_next;
		end
	end

	// ------------------------------------------------------------
	// Search and result
	// ------------------------------------------------------------
	search_state_t           srState_reg, srState_next;
	logic [`CAM_HALF-1:0]    upperHold_reg, upperHold_next;
	logic                    valid_reg, valid_next;
	logic                    upper_reg, upper_next;
	logic                    found_reg, found_next;
	logic [`CAM_ADDR_W-1:0]  addr_reg, addr_next;
	logic [`CAM_HALF-1:0]    lines_reg, lines_next;
	logic                    ready_reg, ready_next;
	logic                    srTake;

	// Searching while a word is half written would compare against stale contents.
	assign srTake = searchValid && ready_reg;

	always_comb begin
		srState_next   = SR_IDLE;
		upperHold_next = upperHold_reg;
		valid_next     = 1'b0;
		upper_next     = 1'b0;
		found_next     = found_reg;
		addr_next      = addr_reg;
		lines_next     = '0;
		case (srState_reg)
			SR_IDLE: begin
				if (srTake) begin
					valid_next = 1'b1;
					found_next = hitAny;
					if (ENCODED_OUT) begin
						addr_next = hitIndex;
					end else begin
						lines_next     = hits[`CAM_HALF-1:0];
						upperHold_next = hits[`CAM_WORDS-1:`CAM_HALF];
						srState_next   = SR_UPPER;
					end
				end
			end
			SR_UPPER: begin
				valid_next = 1'b1;
				upper_next = 1'b1;
				lines_next = upperHold_reg;
			end
			default: srState_next = SR_IDLE;
		endcase
		ready_next = srState_next == SR_IDLE && wrState_next == WR_IDLE && !wrTake;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			srState_reg   <= SR_IDLE;
			upperHold_reg <= '0;
			valid_reg     <= 1'b0;
			upper_reg     <= 1'b0;
			found_reg     <= 1'b0;
			addr_reg      <= '0;
			lines_reg     <= '0;
			ready_reg     <= 1'b0;
		end else begin
			srState_reg   <= srState_next;
			upperHold_reg <= upperHold_next;
			valid_reg     <= valid_next;
			upper_reg     <= upper_next;
			found_reg     <= found_next;
			addr_reg      <= addr_next;
			lines_reg     <= lines_next;
			ready_reg     <= ready_next;
		end
	end

	assign searchReady = ready_reg;
	assign writeBusy   = busy_reg;
	assign matchValid  = valid_reg;
	assign matchUpper  = upper_reg;
	assign matchFound  = found_reg;
	assign matchAddr   = addr_reg;
	assign matchLines  = lines_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	write_plain_a: assert property (
		wrTake && writeReq.care == `CAM_CARE_ALL |=> writeBusy ##1 !writeBusy)
		else $error("plain write did not last two cycles");
	write_masked_a: assert property (
		wrTake && writeReq.care != `CAM_CARE_ALL |=> writeBusy [*2] ##1 !writeBusy)
		else $error("masked write did not last three cycles");
	write_store_a: assert property (
		wrTake |-> ##[2:3] (!writeBusy && storeData_reg[wrHold_reg.addr] == wrHold_reg.data
		&& storeCare_reg[wrHold_reg.addr] == wrHold_reg.care))
		else $error("written word not stored");
	no_search_busy_a: assert property (
		writeBusy |-> !searchReady)
		else $error("search accepted during a write");
	found_flag_a: assert property (
		srTake |=> matchValid && matchFound == $past(hitAny))
		else $error("match-found flag wrong");
	encoded_addr_a: assert property (
		ENCODED_OUT && srTake && $onehot(hits) |=>
		matchValid && (32'h1 << matchAddr) == $past(hits))
		else $error("encoded address wrong");
	unenc_phase_a: assert property (
		!ENCODED_OUT && srTake |=> matchValid && !matchUpper ##1 matchValid && matchUpper)
		else $error("unencoded result not two cycles");
	unenc_lines_a: assert property (
		!ENCODED_OUT && srTake |=> matchLines == $past(hits[`CAM_HALF-1:0])
		##1 matchLines == $past(hits[`CAM_WORDS-1:`CAM_HALF], 2))
		else $error("unencoded lines out of order");

	plain_write_c: cover property (wrTake && writeReq.care == `CAM_CARE_ALL);
	masked_write_c: cover property (wrTake && writeReq.care != `CAM_CARE_ALL);
	multi_hit_c: cover property (srTake && !$onehot0(hits));
	search_hit_c: cover property (srTake && hitAny);
endmodule

// file: testbench/cam_user_model.sv
// Fabric-side user logic that issues writes and searches to the memory block.
`timescale 1ns/10ps
`include "cam_defines.svh"
module cam_user_model
	import cam_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 searchReady,
	input  wire logic                 writeBusy,
	output logic                      searchValid,
	output logic [`CAM_WIDTH-1:0]     searchData,
	output logic                      writeValid,
	output write_req_t                writeReq
);
	initial begin
		searchValid = 1'b0;
		searchData  = '0;
		writeValid  = 1'b0;
		writeReq    = '0;
	end

	// ------------------------------------------------------------
	// Requests
	// ------------------------------------------------------------
	// A new request waits until the block is ready for a search and no write is in flight.
	task automatic wait_idle;
		while (!(searchReady === 1'b1 && writeBusy === 1'b0)) begin
			@(posedge ref_clk);
			#1;
		end
	endtask

	// Released lines show the inverse, so nothing stale can pass for a hold.
	task automatic do_write(input write_req_t req);
		wait_idle();
		writeValid = 1'b1;
		writeReq   = req;
		@(posedge ref_clk);
		#1;
		writeValid = 1'b0;
		writeReq   = ~req;
	endtask

	task automatic issue_search(input logic [`CAM_WIDTH-1:0] d);
		wait_idle();
		searchValid = 1'b1;
		searchData  = d;
		@(posedge ref_clk);
		#1;
		searchValid = 1'b0;
		searchData  = ~d;
	endtask
endmodule

// file: testbench/content_addressable_memory_block_bench.sv
// Self-checking bench for the content-addressable memory in both result forms.
`timescale 1ns/10ps
`include "cam_defines.svh"
module content_addressable_memory_block_bench;
	import cam_pkg::*;
	localparam logic [1023:0] INIT_D = 1024'habcd << 160;
	logic        ref_clk, rst, searchValid, writeValid;
	logic [31:0] searchData;
	write_req_t  writeReq;
	logic        readyE, busyE, validE, upperE, foundE, readyU, busyU, validU, upperU, foundU;
	logic [4:0]  addrE, addrU;
	logic [15:0] linesE, linesU;
	int          errors = 0;
	int          check_count = 0;

	content_addressable_memory_block #(.ENCODED_OUT(1'b1), .INIT_DATA(INIT_D)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .searchValid(searchValid), .searchData(searchData),
		.writeValid(writeValid), .writeReq(writeReq), .searchReady(readyE),
		.writeBusy(busyE), .matchValid(validE), .matchUpper(upperE), .matchFound(foundE),
		.matchAddr(addrE), .matchLines(linesE));
	content_addressable_memory_block #(.ENCODED_OUT(1'b0), .INIT_DATA(INIT_D)) u_dut_raw (
		.ref_clk(ref_clk), .rst(rst), .searchValid(searchValid), .searchData(searchData),
		.writeValid(writeValid), .writeReq(writeReq), .searchReady(readyU),
		.writeBusy(busyU), .matchValid(validU), .matchUpper(upperU), .matchFound(foundU),
		.matchAddr(addrU), .matchLines(linesU));
	cam_user_model u_user (
		.ref_clk(ref_clk), .searchReady(readyE & readyU), .writeBusy(busyE | busyU),
		.searchValid(searchValid), .searchData(searchData), .writeValid(writeValid),
		.writeReq(writeReq));

	// ------------------------------------------------------------
	// Checks and scenarios
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Both unencoded cycles are sampled; the address is judged only for a single match.
	task automatic search(input logic [31:0] d, input logic [4:0] a, input logic f,
			input logic [15:0] lo, input logic [15:0] hi, input logic useAddr);
		int n;
		n = 0;
		u_user.issue_search(d);
		while (validU !== 1'b1 && n < 4) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk({validE, validU, upperE, upperU, foundE, foundU}, {4'b1100, f, f});
		if (useAddr)
			chk(addrE, a);
		chk(linesU, lo);
		@(posedge ref_clk);
		#1;
		chk({validE, validU, upperU}, 3'b011);
		chk(linesU, hi);
		chk({addrU, linesE}, 21'h0);
	endtask

	task automatic write(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c,
			input int busyCycles);
		int n;
		n = 0;
		u_user.do_write('{a, d, c});
		repeat (4) begin
			if (busyE === 1'b1 && busyU === 1'b1)
				n++;
			@(posedge ref_clk);
			#1;
		end
		chk(n, busyCycles);
	endtask

	task automatic wrap_up;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		#20000;
		errors++;
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		#1;
		chk({readyE, busyE, validE, upperE, foundE, addrE, linesE}, '0);
		chk({readyU, busyU, validU, upperU, foundU, linesU}, '0);
		rst = 1'b0;
		search(32'habcd, 5'd5, 1'b1, 16'h0020, 16'h0, 1'b1);
		search(32'h0, 5'd0, 1'b1, 16'hffdf, 16'hffff, 1'b0);
		write(5'd20, 32'h12345678, `CAM_CARE_ALL, `CAM_WR_CYC_PLAIN - 1);
		search(32'h12345678, 5'd20, 1'b1, 16'h0, 16'h0010, 1'b1);
		write(5'd31, 32'hff000000, 32'hff000000, `CAM_WR_CYC_MASK - 1);
		search(32'hff123456, 5'd31, 1'b1, 16'h0, 16'h8000, 1'b1);
		search(32'hfe000000, 5'd0, 1'b0, 16'h0, 16'h0, 1'b0);
		wrap_up();
	end
endmodule
